// ==== hdl/tape_input_checker.sv ====
module tape_input_checker #(
    parameter int MEM_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [7:0] in_char,
    output logic in_ready,
    input wire logic [7:0] stored_char,
    input wire logic [MEM_W-1:0] mem_free,
    input wire logic [15:0] cfg_baud,
    input wire logic protect_pin,
    input wire logic teletype_pin,
    input wire logic vcheck_pin,
    input wire logic op_reset_pin,
    output logic out_valid,
    output tape_check_pkg::tape_word_t out_word,
    input wire logic out_ready,
    output tape_check_pkg::alarm_flags_t alarm,
    output logic [7:0] alarm_code,
    output logic read_halt,
    output logic [7:0] block_count
);

    ////////////////////////////////////////////////////////////////////
    // panel pins: two flops each before anything reads them

    localparam int NPINS = 4;
    wire [NPINS-1:0] pins_raw = {op_reset_pin, vcheck_pin,
                                 teletype_pin, protect_pin};
    logic [NPINS-1:0] pins_meta;
    logic [NPINS-1:0] pins_sync;

    for (genvar g = 0; g < NPINS; g++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                pins_meta[g] <= tape_check_pkg::PIN_RESET;
                pins_sync[g] <= tape_check_pkg::PIN_RESET;
            end else if (ce) begin
                pins_meta[g] <= pins_raw[g];
                pins_sync[g] <= pins_meta[g];
            end
        end
    end

    wire protect = pins_sync[0];
    wire teletype = pins_sync[1];
    wire vcheck = pins_sync[2];
    wire op_reset = pins_sync[3] && ce;

    ////////////////////////////////////////////////////////////////////
    // character classification and checks

    function automatic logic [7:0] code_of(
        input tape_check_pkg::alarm_flags_t f
    );
        if (f.hpar) begin
            code_of = tape_check_pkg::CODE_HPAR;
        end else if (f.vpar) begin
            code_of = tape_check_pkg::CODE_VPAR;
        end else if (f.compare) begin
            code_of = tape_check_pkg::CODE_COMPARE;
        end else if (f.overflow) begin
            code_of = tape_check_pkg::CODE_OVERFLOW;
        end else if (f.baud) begin
            code_of = tape_check_pkg::CODE_BAUD;
        end else begin
            code_of = tape_check_pkg::CODE_NONE;
        end
    endfunction

    logic comment;
    wire accept = ce && in_valid && in_ready;
    wire is_end = in_char == tape_check_pkg::BLOCK_END_CHAR;
    wire is_cout = in_char == tape_check_pkg::CTRL_OUT_CHAR;
    wire is_cin = in_char == tape_check_pkg::CTRL_IN_CHAR;
    wire significant = !comment && !is_cout;
    wire counted = accept && !is_end && significant;
    wire [15:0] required_baud = teletype ? tape_check_pkg::TELETYPE_BAUD
                                         : tape_check_pkg::READER_BAUD;

    tape_check_pkg::alarm_flags_t new_flags;
    assign new_flags.hpar = accept && significant
        && ((^in_char) != tape_check_pkg::PARITY_ODD);
    // odd count: low bit of the counter, end-of-block itself not counted
    assign new_flags.vpar = accept && is_end && vcheck
        && block_count[0];
    assign new_flags.compare = accept && protect
        && (in_char != stored_char);
    assign new_flags.overflow = accept && !protect
        && (mem_free == '0);
    assign new_flags.baud = accept && (cfg_baud != required_baud);

    wire any_bad = |new_flags;

    ////////////////////////////////////////////////////////////////////
    // alarm state: a new fault in a reset cycle still wins

    wire tape_check_pkg::alarm_flags_t kept =
        op_reset ? tape_check_pkg::ALARM_RESET : alarm;
    wire tape_check_pkg::alarm_flags_t next_alarm = kept | new_flags;
    wire next_halt = |next_alarm;
    wire code_free = op_reset
        || alarm_code == tape_check_pkg::CODE_NONE;
    // the first alarm keeps its number until the operator clears it
    wire [7:0] next_code = (code_free && any_bad) ? code_of(new_flags)
        : (op_reset ? tape_check_pkg::CODE_NONE : alarm_code);

    always_ff @(posedge clk) begin
        if (rst) begin
            alarm <= tape_check_pkg::ALARM_RESET;
            alarm_code <= tape_check_pkg::CODE_NONE;
            read_halt <= tape_check_pkg::HALT_RESET;
        end else if (ce) begin
            alarm <= next_alarm;
            alarm_code <= next_code;
            read_halt <= next_halt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-block counter and control-out section tracking

    wire [7:0] next_count = (op_reset || (accept && is_end))
        ? tape_check_pkg::COUNT_RESET
        : (counted ? block_count + 8'h01 : block_count);

    always_ff @(posedge clk) begin
        if (rst) begin
            block_count <= tape_check_pkg::COUNT_RESET;
            comment <= tape_check_pkg::COMMENT_RESET;
        end else if (ce) begin
            block_count <= next_count;
            if (op_reset) begin
                comment <= tape_check_pkg::COMMENT_RESET;
            end else if (accept && is_cout) begin
                comment <= 1'b1;
            end else if (accept && is_cin) begin
                comment <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data path to program memory

    // a failing character is never stored; words of the failing block
    // already buffered are not committed until their end-of-block word,
    // and read_halt tells the store to drop them
    wire push = accept && !any_bad && !protect && !read_halt;
    wire hold = next_halt || op_reset;
    tape_check_pkg::tape_word_t push_word;
    assign push_word.data = in_char;
    assign push_word.block_end = is_end;
    logic buf_ready;

    tape_skid_buffer #(
        .WIDTH($bits(tape_check_pkg::tape_word_t)),
        .DEPTH(2)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .hold(hold),
        .in_valid(push),
        .in_data(push_word),
        .in_ready(buf_ready),
        .out_valid(out_valid),
        .out_data(out_word),
        .out_ready(out_ready)
    );

    // reading stalls on a full buffer, so a receiver stall loses no word
    assign in_ready = buf_ready;

    ////////////////////////////////////////////////////////////////////
    // checks

    a_vpar_raise: assert property (@(posedge clk) disable iff (rst)
        accept && is_end && vcheck && block_count[0]
        |=> alarm.vpar && read_halt)
        else $error("odd block count did not raise vertical alarm");

    a_vpar_code: assert property (@(posedge clk) disable iff (rst)
        accept && is_end && vcheck && block_count[0] && !alarm.hpar
        && !new_flags.hpar && (alarm_code == tape_check_pkg::CODE_NONE)
        |=> alarm_code == tape_check_pkg::CODE_VPAR)
        else $error("vertical alarm shows wrong code");

    a_comment_skip: assert property (@(posedge clk) disable iff (rst)
        ce && !op_reset && (!accept || comment || (is_cout && !is_end))
        && !(accept && is_end)
        |=> block_count == $past(block_count))
        else $error("control section character was counted");

    a_halt_ready: assert property (@(posedge clk) disable iff (rst)
        read_halt |-> !in_ready)
        else $error("reader not stopped while alarm stands");

    a_halt_nostore: assert property (@(posedge clk) disable iff (rst)
        ce && read_halt && !op_reset |=> !in_ready [*2])
        else $error("data accepted after alarm");

    a_reset_clear: assert property (@(posedge clk) disable iff (rst)
        op_reset && !accept |=> alarm == tape_check_pkg::ALARM_RESET
        && alarm_code == tape_check_pkg::CODE_NONE && !read_halt)
        else $error("operator reset did not clear alarm");

    a_vcheck_off: assert property (@(posedge clk) disable iff (rst)
        accept && is_end && !vcheck && !alarm.vpar
        |=> !alarm.vpar)
        else $error("vertical alarm raised with check disabled");

    a_compare_err: assert property (@(posedge clk) disable iff (rst)
        accept && protect && in_char != stored_char
        |=> alarm.compare && read_halt)
        else $error("tape compare mismatch not flagged");

    a_mem_short: assert property (@(posedge clk) disable iff (rst)
        accept && !protect && mem_free == '0 |=> alarm.overflow)
        else $error("memory shortage not flagged");

    a_baud_err: assert property (@(posedge clk) disable iff (rst)
        accept && cfg_baud != required_baud |=> alarm.baud)
        else $error("baud mismatch not flagged");

    a_hpar_err: assert property (@(posedge clk) disable iff (rst)
        accept && significant && ((^in_char) != tape_check_pkg::PARITY_ODD)
        |=> alarm.hpar && !in_ready)
        else $error("horizontal parity failure not flagged");

    a_count_clear: assert property (@(posedge clk) disable iff (rst)
        accept && is_end |=> block_count == tape_check_pkg::COUNT_RESET)
        else $error("block counter not cleared at end of block");

endmodule

// ==== shared/tape_check_pkg.sv ====
// Notes on behaviour
// - odd character count between end-of-block codes raises alarm 002
// - characters from control-out through control-in are not counted
// - vertical parity alarm halts tape reading and shows the alarm
// - after the alarm no data of that block or later blocks is accepted
// - operator reset clears the alarm indication
// - a setting enables the vertical parity check; disabled means no alarm
// - write protected: compare tape with stored program; mismatch is 079
// - too little free program memory while loading raises alarm 070
// - reader runs 4800 baud, teletype 110 baud; rate mismatch raises 085
// - horizontal parity failure outside control section: stop, alarm 001
package tape_check_pkg;

    localparam logic [7:0] BLOCK_END_CHAR = 8'h0A;
    localparam logic [7:0] CTRL_OUT_CHAR = 8'h28;
    localparam logic [7:0] CTRL_IN_CHAR = 8'h29;

    // alarm numbers as shown on the display, in binary
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_HPAR = 8'h01;
    localparam logic [7:0] CODE_VPAR = 8'h02;
    localparam logic [7:0] CODE_OVERFLOW = 8'h46;
    localparam logic [7:0] CODE_COMPARE = 8'h4F;
    localparam logic [7:0] CODE_BAUD = 8'h55;

    localparam logic [15:0] READER_BAUD = 16'h12C0;
    localparam logic [15:0] TELETYPE_BAUD = 16'h006E;

    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic COMMENT_RESET = 1'b0;
    localparam logic HALT_RESET = 1'b0;
    localparam logic PIN_RESET = 1'b0;
    // channel 8 carries even parity over the other seven channels
    localparam logic PARITY_ODD = 1'b0;

    typedef struct packed {
        logic [7:0] data;
        logic block_end;
    } tape_word_t;

    typedef struct packed {
        logic hpar;
        logic vpar;
        logic compare;
        logic overflow;
        logic baud;
    } alarm_flags_t;

    localparam alarm_flags_t ALARM_RESET = '0;

endpackage

// ==== hdl/tape_skid_buffer.sv ====
module tape_skid_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hold,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] entry [DEPTH];
    logic [CW-1:0] count;
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;
    wire [CW-1:0] wpos = pop ? count - 1'b1 : count;
    wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

    // head entry is the output register, so the read side sees a flop
    assign out_data = entry[0];

    always_ff @(posedge clk) begin
        if (ce) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (pop && i + 1 < DEPTH) begin
                    entry[i] <= entry[i+1];
                end
                if (push && wpos == CW'(i)) begin
                    entry[i] <= in_data;
                end
            end
        end
    end

    // ready looks one cycle ahead so it can be a plain register
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            in_ready <= (next_count < DEPTH_C) && !hold;
            out_valid <= next_count != '0;
        end
    end

endmodule

// ==== verification/tape_source.sv ====
module tape_source (
    input wire logic clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_char
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        in_valid = 1'b0;
        in_char = 8'h00;
    end

    // holds one character until the checker takes it, or gives up
    task automatic put(input logic [7:0] c, input int gap, output bit took);
        took = 1'b0;
        repeat (gap) @(negedge clk);
        @(negedge clk);
        in_valid = 1'b1;
        in_char = c;
        for (int n = 0; n < 40 && !took; n++) begin
            if (in_ready === 1'b1) took = 1'b1;
            @(negedge clk);
        end
        in_valid = 1'b0;
        // released lines show no stale character
        in_char = ~c;
    endtask

    // one block; an odd block gets a counted and stored space before its end code
    task automatic put_block(input logic [7:0] q[$], input int gap);
        int cnt;
        bit ctl;
        bit t;
        cnt = 0;
        ctl = 1'b0;
        foreach (q[i]) begin
            if (q[i] == tape_check_pkg::BLOCK_END_CHAR && cnt[0]) begin
                put(8'hA0, gap, t);
            end
            if (q[i] == tape_check_pkg::CTRL_OUT_CHAR) ctl = 1'b1;
            else if (q[i] == tape_check_pkg::CTRL_IN_CHAR) ctl = 1'b0;
            else if (!ctl && q[i] != tape_check_pkg::BLOCK_END_CHAR) cnt++;
            put(q[i], gap, t);
        end
    endtask
endmodule

// ==== verification/program_tape_input_checker_tb.sv ====
module program_tape_input_checker_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, ce, in_valid, in_ready, out_valid, out_ready, read_halt;
    logic [7:0] in_char, stored_char, alarm_code, block_count;
    logic [15:0] mem_free, cfg_baud;
    logic protect_pin, teletype_pin, vcheck_pin, op_reset_pin, bad_cmp;
    tape_check_pkg::tape_word_t out_word;
    tape_check_pkg::alarm_flags_t alarm;
    tape_check_pkg::tape_word_t exp_q[$];
    logic [7:0] blk[$];
    int err_count, checked, seed;
    bit took;

    // a wrong stored copy is the inverse of the tape character
    assign stored_char = bad_cmp ? ~in_char : in_char;

    tape_input_checker dut (.clk(clk), .rst(rst), .ce(ce),
        .in_valid(in_valid), .in_char(in_char), .in_ready(in_ready),
        .stored_char(stored_char), .mem_free(mem_free),
        .cfg_baud(cfg_baud), .protect_pin(protect_pin),
        .teletype_pin(teletype_pin), .vcheck_pin(vcheck_pin),
        .op_reset_pin(op_reset_pin), .out_valid(out_valid),
        .out_word(out_word), .out_ready(out_ready), .alarm(alarm),
        .alarm_code(alarm_code), .read_halt(read_halt),
        .block_count(block_count));

    tape_source src (.clk(clk), .in_ready(in_ready),
        .in_valid(in_valid), .in_char(in_char));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    always @(posedge clk) begin
        if (ce === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("out_word", 9'h1FF, out_word);
            else chk("out_word", exp_q.pop_front(), out_word);
        end
    end

    // the store stalls about one cycle in four
    always @(negedge clk) out_ready <= ($random(seed) & 3) != 0;

    task automatic send(input logic [7:0] c, input bit keep);
        if (keep) exp_q.push_back({c, c == tape_check_pkg::BLOCK_END_CHAR});
        src.put(c, $random(seed) & 1, took);
    endtask

    task automatic letter(input bit keep);
        logic [7:0] c;
        c = 8'h41 + 8'($random(seed) & 15);
        send({^c[6:0], c[6:0]}, keep);
    endtask

    task automatic alarm_is(input logic [7:0] code);
        tape_check_pkg::alarm_flags_t f;
        // each scenario raises one alarm, so the flags follow the code
        f = tape_check_pkg::ALARM_RESET;
        f.hpar = code == tape_check_pkg::CODE_HPAR;
        f.vpar = code == tape_check_pkg::CODE_VPAR;
        f.compare = code == tape_check_pkg::CODE_COMPARE;
        f.overflow = code == tape_check_pkg::CODE_OVERFLOW;
        f.baud = code == tape_check_pkg::CODE_BAUD;
        @(negedge clk);
        chk("alarm_code", {1'b0, code}, {1'b0, alarm_code});
        chk("read_halt", {8'h00, code != 8'h00}, {8'h00, read_halt});
        chk("alarm", {4'h0, f}, {4'h0, alarm});
    endtask

    task automatic op_reset();
        op_reset_pin = 1'b1;
        repeat (5) @(negedge clk);
        op_reset_pin = 1'b0;
        repeat (4) @(negedge clk);
        alarm_is(tape_check_pkg::CODE_NONE);
        chk("block_count", 9'h000, {1'b0, block_count});
    endtask

    task automatic give_verdict();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        err_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32362;
        rst = 1'b1;
        ce = 1'b1;
        out_ready = 1'b0;
        bad_cmp = 1'b0;
        mem_free = 16'h0100;
        cfg_baud = tape_check_pkg::READER_BAUD;
        protect_pin = 1'b0;
        teletype_pin = 1'b0;
        vcheck_pin = 1'b1;
        op_reset_pin = 1'b0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        alarm_is(tape_check_pkg::CODE_NONE);
        send(8'h41, 1);
        send(8'h28, 1);
        send(8'h43, 1);
        send(8'h29, 1);
        send(8'h42, 1);
        chk("block_count", 9'h002, {1'b0, block_count});
        // clock enable low: an offered character must leave no trace
        ce = 1'b0;
        letter(0);
        chk("block_count", 9'h002, {1'b0, block_count});
        chk("alarm_code", 9'h000, {1'b0, alarm_code});
        ce = 1'b1;
        send(8'h0A, 1);
        alarm_is(tape_check_pkg::CODE_NONE);
        for (int b = 0; b < 3; b++) begin
            repeat (6) letter(1);
            send(8'h0A, 1);
        end
        alarm_is(tape_check_pkg::CODE_NONE);
        blk = '{8'h41, 8'h0A};
        exp_q.push_back({8'h41, 1'b0});
        exp_q.push_back({8'hA0, 1'b0});
        exp_q.push_back({8'h0A, 1'b1});
        src.put_block(blk, 0);
        alarm_is(tape_check_pkg::CODE_NONE);
        vcheck_pin = 1'b0;
        repeat (4) @(negedge clk);
        letter(1);
        send(8'h0A, 1);
        alarm_is(tape_check_pkg::CODE_NONE);
        vcheck_pin = 1'b1;
        repeat (4) @(negedge clk);
        letter(1);
        send(8'h0A, 0);
        alarm_is(tape_check_pkg::CODE_VPAR);
        letter(0);
        chk("took", 9'h000, {8'h00, took});
        op_reset();
        letter(1);
        send(8'h43, 0);
        alarm_is(tape_check_pkg::CODE_HPAR);
        op_reset();
        letter(1);
        letter(1);
        send(8'h0A, 1);
        alarm_is(tape_check_pkg::CODE_NONE);
        mem_free = 16'h0000;
        letter(0);
        alarm_is(tape_check_pkg::CODE_OVERFLOW);
        mem_free = 16'h0100;
        op_reset();
        cfg_baud = tape_check_pkg::TELETYPE_BAUD;
        letter(0);
        alarm_is(tape_check_pkg::CODE_BAUD);
        op_reset();
        teletype_pin = 1'b1;
        repeat (4) @(negedge clk);
        letter(1);
        letter(1);
        send(8'h0A, 1);
        alarm_is(tape_check_pkg::CODE_NONE);
        teletype_pin = 1'b0;
        cfg_baud = tape_check_pkg::READER_BAUD;
        protect_pin = 1'b1;
        repeat (4) @(negedge clk);
        letter(0);
        letter(0);
        send(8'h0A, 0);
        alarm_is(tape_check_pkg::CODE_NONE);
        bad_cmp = 1'b1;
        letter(0);
        alarm_is(tape_check_pkg::CODE_COMPARE);
        bad_cmp = 1'b0;
        protect_pin = 1'b0;
        op_reset();
        for (int n = 0; n < 100 && exp_q.size() > 0; n++) @(negedge clk);
        chk("exp_q", 9'h000, 9'(exp_q.size()));
        give_verdict();
    end
endmodule
